// ### design/pss_consts.svh
// constants of the power state sequencer: timing, resource file, sequence store
// assumes inclusion by bare name from the package and the design modules
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// timing
`define PSS_CLK_HZ 250000000
`define PSS_RC_HZ 32768
`define PSS_TICK_CYCLES (`PSS_CLK_HZ / `PSS_RC_HZ)
`define PSS_TICK_W 13
`define PSS_HW_INIT_TICKS 3'h4
`define PSS_HW_CNT_W 3

// resource register file
`define PSS_NUM_RES 8
`define PSS_RES_AW 3
`define PSS_RES_DW 8
`define PSS_RES_ON_BIT 0
`define PSS_LINK_SHIFT 4
`define PSS_RES_DEFAULTS 64'h0000_1000_0000_0000

// sequence step: {last, io rail mark, address, data}
`define PSS_STEP_W 13
`define PSS_STEP_LAST 12
`define PSS_STEP_IO 11
`define PSS_STEP_ADDR_HI 10
`define PSS_STEP_ADDR_LO 8
`define PSS_STEP_DATA_HI 7
`define PSS_IDX_W 4
`define PSS_ROM_DEPTH 12
`define PSS_IDX_ONE 4'h1

// sequence start addresses
`define PSS_START_OFF_TO_ACTIVE 4'h0
`define PSS_START_ACTIVE_TO_OFF 4'h4
`define PSS_START_ACTIVE_TO_SLEEP 4'h8
`define PSS_START_SLEEP_TO_ACTIVE 4'hA
`define PSS_START_SLEEP_TO_OFF 4'h4

// one-time-programmed sequence contents
`define PSS_ROM_0 13'h0001
`define PSS_ROM_1 13'h0101
`define PSS_ROM_2 13'h0A01
`define PSS_ROM_3 13'h1301
`define PSS_ROM_4 13'h0300
`define PSS_ROM_5 13'h0200
`define PSS_ROM_6 13'h0100
`define PSS_ROM_7 13'h1000
`define PSS_ROM_8 13'h0303
`define PSS_ROM_9 13'h1100
`define PSS_ROM_10 13'h0101
`define PSS_ROM_11 13'h1301

`endif

// ### design/pss_pkg.sv
// types shared by the power state sequencer modules
// assumes pss_consts.svh on the include path
`include "pss_consts.svh"

package pss_pkg;

  typedef enum logic [2:0] {
    ps_no_supply, ps_backup, ps_hw_init, ps_off, ps_active, ps_sleep, ps_seq
  } pss_pstate_t;

  typedef enum logic [2:0] {
    off_to_active_seq, active_to_off_seq, active_to_sleep_seq,
    sleep_to_active_seq, sleep_to_off_seq
  } pss_seq_t;

  typedef enum logic [1:0] {
    pol_skip, pol_continue, pol_stop_io, pol_halt
  } pss_policy_t;

  typedef enum logic [1:0] {
    eng_idle, eng_check, eng_run
  } pss_eng_t;

  typedef logic [`PSS_STEP_W-1:0] pss_step_t;

endpackage

// ### design/pss_seq_if.sv
// link between the power state machine and the sequence engine
// assumes one clock domain; ctrl is the state machine, eng the engine
`include "pss_consts.svh"

interface pss_seq_if;
  import pss_pkg::*;
  logic start;
  pss_seq_t seq_sel;
  pss_policy_t policy;
  logic tick;
  logic abort;
  pss_step_t otp_ref;
  logic busy;
  logic done;
  logic halted;
  logic wr_en;
  logic [`PSS_RES_AW-1:0] wr_addr;
  logic [`PSS_RES_DW-1:0] wr_data;
  logic crc_err;

  modport ctrl (
    output start, seq_sel, policy, tick, abort, otp_ref,
    input busy, done, halted, wr_en, wr_addr, wr_data, crc_err
  );
  modport eng (
    input start, seq_sel, policy, tick, abort, otp_ref,
    output busy, done, halted, wr_en, wr_addr, wr_data, crc_err
  );
endinterface

// ### design/pss_seq_engine.sv
// sequence engine: integrity check, then one stored register access per rc tick
// assumes start is a one-cycle pulse given only while idle
`include "pss_consts.svh"

module pss_seq_engine
  import pss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // state machine side
  pss_seq_if.eng sq
);

  pss_eng_t st_q, st_d;
  logic [`PSS_IDX_W-1:0] idx_q, idx_d;
  logic stop_q, stop_d;
  logic done_q, done_d;
  logic halted_q, halted_d;
  logic wr_en_q, wr_en_d;
  logic [`PSS_RES_AW-1:0] addr_q, addr_d;
  logic [`PSS_RES_DW-1:0] data_q, data_d;
  logic crc_q, crc_d;
  pss_step_t step;

  // contents are constants, so run time can never alter a sequence
  function automatic pss_step_t pss_rom(input logic [`PSS_IDX_W-1:0] i);
    case (i)
      4'h0: pss_rom = `PSS_ROM_0;
      4'h1: pss_rom = `PSS_ROM_1;
      4'h2: pss_rom = `PSS_ROM_2;
      4'h3: pss_rom = `PSS_ROM_3;
      4'h4: pss_rom = `PSS_ROM_4;
      4'h5: pss_rom = `PSS_ROM_5;
      4'h6: pss_rom = `PSS_ROM_6;
      4'h7: pss_rom = `PSS_ROM_7;
      4'h8: pss_rom = `PSS_ROM_8;
      4'h9: pss_rom = `PSS_ROM_9;
      4'hA: pss_rom = `PSS_ROM_10;
      4'hB: pss_rom = `PSS_ROM_11;
      default: pss_rom = '0;
    endcase
  endfunction

  function automatic pss_step_t pss_rom_sum();
    pss_step_t s;
    s = '0;
    for (int i = 0; i < `PSS_ROM_DEPTH; i++) begin
      s = s ^ pss_rom(i[`PSS_IDX_W-1:0]);
    end
    return s;
  endfunction

  function automatic logic [`PSS_IDX_W-1:0] pss_seq_start(input pss_seq_t s);
    unique case (s)
      off_to_active_seq: return `PSS_START_OFF_TO_ACTIVE;
      active_to_off_seq: return `PSS_START_ACTIVE_TO_OFF;
      active_to_sleep_seq: return `PSS_START_ACTIVE_TO_SLEEP;
      sleep_to_active_seq: return `PSS_START_SLEEP_TO_ACTIVE;
      sleep_to_off_seq: return `PSS_START_SLEEP_TO_OFF;
    endcase
  endfunction

  assign step = pss_rom(idx_q);

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    stop_d = stop_q;
    done_d = 1'b0;
    halted_d = halted_q;
    wr_en_d = 1'b0;
    addr_d = addr_q;
    data_d = data_q;
    crc_d = 1'b0;
    unique case (st_q)
      eng_idle: begin
        if (sq.start) begin
          idx_d = pss_seq_start(sq.seq_sel);
          stop_d = 1'b0;
          halted_d = 1'b0;
          if (sq.seq_sel == off_to_active_seq && sq.policy != pol_skip) begin
            st_d = eng_check;
          end else begin
            st_d = eng_run;
          end
        end
      end
      eng_check: begin
        if (sq.tick) begin
          st_d = eng_run;
          if (pss_rom_sum() != sq.otp_ref) begin
            crc_d = 1'b1;
            if (sq.policy == pol_halt) begin
              done_d = 1'b1;
              halted_d = 1'b1;
              st_d = eng_idle;
            end
            stop_d = (sq.policy == pol_stop_io);
          end
        end
      end
      eng_run: begin
        if (sq.tick) begin
          wr_en_d = 1'b1;
          addr_d = step[`PSS_STEP_ADDR_HI:`PSS_STEP_ADDR_LO];
          data_d = step[`PSS_STEP_DATA_HI:0];
          if (step[`PSS_STEP_LAST] || (stop_q && step[`PSS_STEP_IO])) begin
            done_d = 1'b1;
            halted_d = stop_q;
            st_d = eng_idle;
          end else begin
            idx_d = idx_q + `PSS_IDX_ONE;
          end
        end
      end
    endcase
    // a supply drop ends the sequence at once; no further access may land
    if (sq.abort) begin
      st_d = eng_idle;
      wr_en_d = 1'b0;
      done_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= eng_idle;
      idx_q <= '0;
      stop_q <= 1'b0;
      done_q <= 1'b0;
      halted_q <= 1'b0;
      wr_en_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      crc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      stop_q <= stop_d;
      done_q <= done_d;
      halted_q <= halted_d;
      wr_en_q <= wr_en_d;
      addr_q <= addr_d;
      data_q <= data_d;
      crc_q <= crc_d;
    end
  end

  assign sq.busy = (st_q != eng_idle);
  assign sq.done = done_q;
  assign sq.halted = halted_q;
  assign sq.wr_en = wr_en_q;
  assign sq.wr_addr = addr_q;
  assign sq.wr_data = data_q;
  assign sq.crc_err = crc_q;

endmodule // pss_seq_engine

// ### design/pss_power_state_sequencer.sv
// power state sequencer: supply states, request arbitration, resource register file
// assumes all inputs synchronous to clk; request inputs are one-cycle pulses
//
// Functional notes
// - four request kinds drive five fixed sequences
// - unsequenced resources keep their stored defaults
// - resource state lives in host-writable register bits
// - arbitration orders pending requests before the machine
// - sequence chosen from supplies, temperature and request
// - engine fetches stored sequence and executes steps
// - supply below reset threshold means no supply
// - between reset and system-low thresholds means backup
// - above system-low without start-up means off
// - active only after start-up above system-high
// - sleep applies low-power settings, keeps linked subsystems
// - sequences do nothing in no-supply or backup
// - hardware finishes off entry, then hands over
// - only five transitions between off, active, sleep
// - steps are fixed register accesses, never modifiable
// - optional integrity check opens every power-up
// - policy: skip check, or check and continue
// - policy: stop at io rail, or halt
// - any integrity error raises the host flag
// - steps paced by the 32 kHz oscillator tick
// - off requests win, ungated, over sleep and wake
// - sleep only while no unmasked interrupt pending
// - wake only in sleep, to active or off
`include "pss_consts.svh"

module pss_power_state_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned TICK_DIV = `PSS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // supply and temperature comparators
  input wire logic por_ok,
  input wire logic sys_lo_ok,
  input wire logic sys_hi_ok,
  input wire logic hot_die,
  // on-request gates
  input wire logic pwrdown_gate,
  input wire logic reset_in_gate,
  // requests
  input wire logic on_req,
  input wire logic off_req,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic wake_to_off,
  input wire logic irq_pending,
  // integrity check
  input wire pss_policy_t check_policy,
  input wire pss_step_t otp_check_ref,
  input wire logic irq_clear,
  // host register writes
  input wire logic host_wr_en,
  input wire logic [`PSS_RES_AW-1:0] host_wr_addr,
  input wire logic [`PSS_RES_DW-1:0] host_wr_data,
  // state and resources
  output pss_pstate_t power_state_q,
  output logic [`PSS_NUM_RES-1:0][`PSS_RES_DW-1:0] res_regs_q,
  output logic [`PSS_NUM_RES-1:0] sub_active_q,
  output logic always_on_rail_q,
  output logic seq_busy_q,
  output logic integrity_error_irq_q
);

  pss_seq_if sq();

  logic [`PSS_TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  pss_pstate_t state_d;
  pss_seq_t seq_q, seq_d;
  logic start_q, start_d;
  logic [`PSS_HW_CNT_W-1:0] hw_cnt_q, hw_cnt_d;
  logic pend_on_q, pend_off_q, pend_sleep_q, pend_wake_q;
  logic pend_on_d, pend_off_d, pend_sleep_d, pend_wake_d;
  logic clr_on, clr_off, clr_sleep, clr_wake;
  logic [`PSS_NUM_RES-1:0][`PSS_RES_DW-1:0] res_d;
  logic [`PSS_NUM_RES-1:0] sub_d;
  logic irq_d;
  logic on_ok;

  function automatic pss_pstate_t pss_seq_target(input pss_seq_t s);
    unique case (s)
      off_to_active_seq, sleep_to_active_seq: return ps_active;
      active_to_sleep_seq: return ps_sleep;
      active_to_off_seq, sleep_to_off_seq: return ps_off;
    endcase
  endfunction

  // rc oscillator pacing as an enable; the divide is truncated, so the tick runs fast
  // by under one clock per period
  always_comb begin
    tick_cnt_d = tick_cnt_q + 1'b1;
    tick_d = 1'b0;
    if (tick_cnt_q == TICK_DIV[`PSS_TICK_W-1:0] - 1'b1) begin
      tick_cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  assign on_ok = sys_hi_ok && !hot_die && !pwrdown_gate && !reset_in_gate;

  always_comb begin
    state_d = power_state_q;
    seq_d = seq_q;
    start_d = 1'b0;
    hw_cnt_d = hw_cnt_q;
    clr_on = 1'b0;
    clr_off = 1'b0;
    clr_sleep = 1'b0;
    clr_wake = 1'b0;
    res_d = res_regs_q;
    unique case (power_state_q)
      ps_no_supply, ps_backup: begin
        res_d = `PSS_RES_DEFAULTS;
        hw_cnt_d = '0;
        state_d = ps_hw_init;
        {clr_on, clr_off, clr_sleep, clr_wake} = 4'hF;
      end
      ps_hw_init: begin
        // fixed hardware bring-up; the sequencer only takes over in off
        res_d = `PSS_RES_DEFAULTS;
        {clr_on, clr_off, clr_sleep, clr_wake} = 4'hF;
        if (tick_q) begin
          hw_cnt_d = hw_cnt_q + 1'b1;
          if (hw_cnt_q == `PSS_HW_INIT_TICKS) begin
            state_d = ps_off;
          end
        end
      end
      ps_off: begin
        {clr_off, clr_sleep, clr_wake} = 3'h7;
        if (pend_on_q) begin
          clr_on = 1'b1;
          if (on_ok) begin
            seq_d = off_to_active_seq;
            start_d = 1'b1;
            state_d = ps_seq;
          end
        end
      end
      ps_active: begin
        {clr_on, clr_wake} = 2'h3;
        if (pend_off_q) begin
          clr_off = 1'b1;
          seq_d = active_to_off_seq;
          start_d = 1'b1;
          state_d = ps_seq;
        end else if (pend_sleep_q) begin
          clr_sleep = 1'b1;
          if (!irq_pending) begin
            seq_d = active_to_sleep_seq;
            start_d = 1'b1;
            state_d = ps_seq;
          end
        end
      end
      ps_sleep: begin
        {clr_on, clr_sleep} = 2'h3;
        if (pend_off_q) begin
          clr_off = 1'b1;
          clr_wake = 1'b1;
          seq_d = sleep_to_off_seq;
          start_d = 1'b1;
          state_d = ps_seq;
        end else if (pend_wake_q) begin
          clr_wake = 1'b1;
          seq_d = wake_to_off ? sleep_to_off_seq : sleep_to_active_seq;
          start_d = 1'b1;
          state_d = ps_seq;
        end
      end
      ps_seq: begin
        // pending requests stay untouched until the sequence reports done
        if (sq.done) begin
          state_d = sq.halted ? ps_off : pss_seq_target(seq_q);
        end
      end
    endcase
    if (power_state_q != ps_no_supply && power_state_q != ps_backup
        && power_state_q != ps_hw_init) begin
      if (sq.wr_en) begin
        res_d[sq.wr_addr] = sq.wr_data;
      end else if (host_wr_en) begin
        res_d[host_wr_addr] = host_wr_data;
      end
    end
    if (!por_ok) begin
      state_d = ps_no_supply;
      start_d = 1'b0;
    end else if (!sys_lo_ok) begin
      state_d = ps_backup;
      start_d = 1'b0;
    end
  end

  // set wins over clear so a request in the consuming cycle survives
  assign pend_on_d = (pend_on_q & ~clr_on) | on_req;
  assign pend_off_d = (pend_off_q & ~clr_off) | off_req;
  assign pend_sleep_d = (pend_sleep_q & ~clr_sleep) | sleep_req;
  assign pend_wake_d = (pend_wake_q & ~clr_wake) | wake_req;
  assign irq_d = (integrity_error_irq_q & ~irq_clear) | sq.crc_err;

  always_comb begin
    for (int i = 0; i < `PSS_NUM_RES; i++) begin
      sub_d[i] = res_d[i][`PSS_RES_ON_BIT];
    end
    sub_d = sub_d | (sub_d << `PSS_LINK_SHIFT);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_state_q <= ps_no_supply;
      seq_q <= off_to_active_seq;
      start_q <= 1'b0;
      hw_cnt_q <= '0;
      pend_on_q <= 1'b0;
      pend_off_q <= 1'b0;
      pend_sleep_q <= 1'b0;
      pend_wake_q <= 1'b0;
      res_regs_q <= `PSS_RES_DEFAULTS;
      sub_active_q <= '0;
      always_on_rail_q <= 1'b0;
      seq_busy_q <= 1'b0;
      integrity_error_irq_q <= 1'b0;
    end else begin
      power_state_q <= state_d;
      seq_q <= seq_d;
      start_q <= start_d;
      hw_cnt_q <= hw_cnt_d;
      pend_on_q <= pend_on_d;
      pend_off_q <= pend_off_d;
      pend_sleep_q <= pend_sleep_d;
      pend_wake_q <= pend_wake_d;
      res_regs_q <= res_d;
      sub_active_q <= sub_d;
      always_on_rail_q <= (state_d != ps_no_supply);
      seq_busy_q <= (state_d == ps_seq);
      integrity_error_irq_q <= irq_d;
    end
  end

  assign sq.start = start_q;
  assign sq.seq_sel = seq_q;
  assign sq.policy = check_policy;
  assign sq.tick = tick_q;
  assign sq.abort = !sys_lo_ok || !por_ok;
  assign sq.otp_ref = otp_check_ref;

  pss_seq_engine u_engine (
    .clk(clk),
    .reset_n(reset_n),
    .sq(sq)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  no_supply_a: assert property (!por_ok |=> power_state_q == ps_no_supply)
    else $error("low supply did not force no-supply");
  backup_a: assert property (por_ok && !sys_lo_ok |=> power_state_q == ps_backup)
    else $error("supply between thresholds did not force backup");
  up_gate_a: assert property (
    power_state_q == ps_off && pend_on_q && !on_ok && por_ok && sys_lo_ok
    |=> power_state_q == ps_off)
    else $error("power-up started while gated");
  off_wins_a: assert property (
    power_state_q == ps_active && pend_off_q && sys_lo_ok && por_ok
    |=> power_state_q == ps_seq && seq_q == active_to_off_seq ##1 sq.busy)
    else $error("off request not taken first");
  sleep_block_a: assert property (
    power_state_q == ps_active && pend_sleep_q && !pend_off_q && irq_pending && sys_lo_ok
    |=> power_state_q == ps_active)
    else $error("sleep entered with pending interrupt");
  wake_src_a: assert property (
    start_q && (seq_q == sleep_to_active_seq || (seq_q == sleep_to_off_seq && !$past(pend_off_q)))
    |-> $past(power_state_q) == ps_sleep)
    else $error("wake sequence outside sleep");
  seq_hold_a: assert property (
    power_state_q == ps_seq && !sq.done && por_ok && sys_lo_ok |=> power_state_q == ps_seq)
    else $error("sequence left before done");
  irq_set_a: assert property (sq.crc_err |=> integrity_error_irq_q)
    else $error("integrity error not flagged");
  tick_gap_a: assert property (tick_q |=> !tick_q [*2])
    else $error("oscillator tick too frequent");
  quiet_a: assert property (!sys_lo_ok |=> !sq.wr_en)
    else $error("sequence access during low supply");

endmodule // pss_power_state_sequencer

// ### tb/pss_host_model.sv
// host-side request source: turns one bench strobe into one-cycle request pulses
// assumes the bench drives fire and kind by non-blocking assignment at a rising edge
module pss_host_model (
  // clock
  input wire logic clk,
  // bench command, kind is {off, sleep, wake, on}
  input wire logic fire,
  input wire logic [3:0] kind,
  // request pins
  output logic on_req,
  output logic off_req,
  output logic sleep_req,
  output logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // pulses last exactly one cycle, the device latches them itself
  always_ff @(posedge clk) begin
    {off_req, sleep_req, wake_req, on_req} <= fire ? kind : 4'h0;
  end
endmodule // pss_host_model

// ### tb/pss_power_state_sequencer_tb_top.sv
// self-checking bench of the power state sequencer
// assumes TICK_DIV shortened to 8 so every sequence step lands within tens of cycles
module pss_power_state_sequencer_tb_top;
  import pss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] K_ON = 4'h1, K_WAKE = 4'h2, K_SLP = 4'h4, K_OFF = 4'h8;
  logic clk, reset_n, por_ok, sys_lo_ok, sys_hi_ok, hot_die, pwrdown_gate, reset_in_gate;
  logic on_req, off_req, sleep_req, wake_req, wake_to_off, irq_pending, irq_clear;
  logic fire, host_wr_en;
  logic [3:0] kind;
  pss_policy_t check_policy;
  pss_step_t otp_check_ref;
  logic [2:0] host_wr_addr;
  logic [7:0] host_wr_data;
  pss_pstate_t power_state_q;
  logic [7:0][7:0] res_regs_q;
  logic [7:0] sub_active_q;
  logic always_on_rail_q, seq_busy_q, integrity_error_irq_q;
  logic [7:0] exp_r [8];
  int num_errors, total_checks, cycles, seed;

  pss_power_state_sequencer #(.TICK_DIV(8)) dut (.clk(clk), .reset_n(reset_n),
    .por_ok(por_ok), .sys_lo_ok(sys_lo_ok), .sys_hi_ok(sys_hi_ok), .hot_die(hot_die),
    .pwrdown_gate(pwrdown_gate), .reset_in_gate(reset_in_gate), .on_req(on_req),
    .off_req(off_req), .sleep_req(sleep_req), .wake_req(wake_req),
    .wake_to_off(wake_to_off), .irq_pending(irq_pending), .check_policy(check_policy),
    .otp_check_ref(otp_check_ref), .irq_clear(irq_clear), .host_wr_en(host_wr_en),
    .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data),
    .power_state_q(power_state_q), .res_regs_q(res_regs_q), .sub_active_q(sub_active_q),
    .always_on_rail_q(always_on_rail_q), .seq_busy_q(seq_busy_q),
    .integrity_error_irq_q(integrity_error_irq_q));
  pss_host_model host (.clk(clk), .fire(fire), .kind(kind), .on_req(on_req),
    .off_req(off_req), .sleep_req(sleep_req), .wake_req(wake_req));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [63:0] exp_regs();
    logic [63:0] v;
    for (int i = 0; i < 8; i++) v[8*i +: 8] = exp_r[i];
    return v;
  endfunction

  // linked subsystems 4..7 follow resources 0..3 as well as their own
  function automatic logic [7:0] exp_sub();
    logic [7:0] s;
    for (int i = 0; i < 8; i++) s[i] = exp_r[i][0] | (i > 3 && exp_r[(i + 4) % 8][0]);
    return s;
  endfunction

  function automatic void set_defaults();
    for (int i = 0; i < 8; i++) exp_r[i] = 8'h00;
    exp_r[5] = 8'h10;
  endfunction

  function automatic void set_low4(input int n, input logic [7:0] v);
    for (int i = 0; i < n; i++) exp_r[i] = v;
  endfunction

  task automatic chk_all(input pss_pstate_t s);
    chk(64'(power_state_q), 64'(s), "state");
    chk(res_regs_q, exp_regs(), "resources");
    chk(64'(sub_active_q), 64'(exp_sub()), "subsystems");
    chk(64'(seq_busy_q), 64'(s == ps_seq), "busy");
    chk(64'(always_on_rail_q), 64'(s != ps_no_supply), "always-on rail");
  endtask

  task automatic req(input logic [3:0] k);
    @(posedge clk);
    fire <= 1'b1;
    kind <= k;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic wait_st(input pss_pstate_t s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (power_state_q !== s && n < 400);
    if (power_state_q !== s) chk(64'(power_state_q), 64'(s), "state wait");
  endtask

  task automatic idle_chk(input pss_pstate_t s);
    repeat (8) @(posedge clk);
    #1;
    chk(64'(power_state_q), 64'(s), "request dropped");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    {reset_n, por_ok, sys_lo_ok, sys_hi_ok, hot_die, pwrdown_gate, reset_in_gate} = '0;
    {wake_to_off, irq_pending, irq_clear, fire, host_wr_en} = '0;
    kind = 4'h0;
    check_policy = pol_skip;
    otp_check_ref = 13'h0803;
    host_wr_addr = 3'h0;
    host_wr_data = 8'h00;
    seed = 19;
    set_defaults();
    repeat (8) @(posedge clk);
    #1;
    chk_all(ps_no_supply);
    reset_n <= 1'b1;
    por_ok <= 1'b1;
    wait_st(ps_backup);
    chk(64'(always_on_rail_q), 64'h1, "always-on rail");
    sys_lo_ok <= 1'b1;
    sys_hi_ok <= 1'b1;
    wait_st(ps_hw_init);
    wait_st(ps_off);
    chk_all(ps_off);
    // each on-request gate in turn must block power-up
    for (int g = 0; g < 4; g++) begin
      @(posedge clk);
      {sys_hi_ok, hot_die, pwrdown_gate, reset_in_gate} <= 4'b1000 ^ (4'h8 >> g);
      req(K_ON);
      idle_chk(ps_off);
      {sys_hi_ok, hot_die, pwrdown_gate, reset_in_gate} <= 4'b1000;
    end
    req(K_ON);
    wait_st(ps_seq);
    chk(64'(seq_busy_q), 64'h1, "busy in sequence");
    req(K_SLP);
    wait_st(ps_active);
    set_low4(4, 8'h01);
    chk_all(ps_active);
    wait_st(ps_sleep);
    exp_r[3] = 8'h03;
    exp_r[1] = 8'h00;
    chk_all(ps_sleep);
    req(K_ON);
    idle_chk(ps_sleep);
    req(K_WAKE);
    wait_st(ps_active);
    exp_r[1] = 8'h01;
    exp_r[3] = 8'h01;
    chk_all(ps_active);
    req(K_ON | K_WAKE);
    idle_chk(ps_active);
    @(posedge clk);
    host_wr_en <= 1'b1;
    host_wr_addr <= 3'h6;
    host_wr_data <= 8'($random(seed));
    @(posedge clk);
    host_wr_en <= 1'b0;
    exp_r[6] = host_wr_data;
    @(posedge clk);
    #1;
    chk_all(ps_active);
    irq_pending <= 1'b1;
    req(K_SLP);
    idle_chk(ps_active);
    irq_pending <= 1'b0;
    req(K_OFF | K_SLP | K_ON);
    wait_st(ps_off);
    set_low4(4, 8'h00);
    chk_all(ps_off);
    req(K_ON);
    wait_st(ps_active);
    req(K_SLP);
    wait_st(ps_sleep);
    wake_to_off <= 1'b1;
    req(K_WAKE);
    wait_st(ps_off);
    wake_to_off <= 1'b0;
    set_low4(4, 8'h00);
    chk_all(ps_off);
    // every check policy against a corrupted reference
    for (int p = 0; p < 4; p++) begin
      check_policy <= pss_policy_t'(p);
      otp_check_ref <= 13'h0803 ^ 13'(($random(seed) & 32'hFFF) | 32'h1);
      req(K_ON);
      wait_st(ps_seq);
      wait_st(p < 2 ? ps_active : ps_off);
      set_low4(p < 2 ? 4 : (p == 2 ? 3 : 0), 8'h01);
      chk_all(p < 2 ? ps_active : ps_off);
      chk(64'(integrity_error_irq_q), 64'(p != 0), "integrity flag");
      irq_clear <= 1'b1;
      @(posedge clk);
      irq_clear <= 1'b0;
      if (p < 2) begin
        req(K_OFF);
        wait_st(ps_off);
        set_low4(4, 8'h00);
      end
    end
    otp_check_ref <= 13'h0803;
    check_policy <= pol_halt;
    req(K_ON);
    wait_st(ps_active);
    set_low4(4, 8'h01);
    chk_all(ps_active);
    chk(64'(integrity_error_irq_q), 64'h0, "integrity flag clean");
    req(K_OFF);
    wait_st(ps_seq);
    repeat (12) @(posedge clk);
    sys_lo_ok <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    set_defaults();
    chk_all(ps_backup);
    sys_lo_ok <= 1'b1;
    wait_st(ps_off);
    chk_all(ps_off);
    por_ok <= 1'b0;
    wait_st(ps_no_supply);
    chk(64'(always_on_rail_q), 64'h0, "always-on rail");
    final_report();
  end
endmodule // pss_power_state_sequencer_tb_top
